// File: sfp_map.svh
`ifndef SFP_MAP_SVH
`define SFP_MAP_SVH

// ****************************************
// sizes
// ****************************************
`define SFP_NUM_REQ       12
`define SFP_NUM_SLV       10
`define SFP_DATA_W        128
`define SFP_CFG_W         32
`define SFP_NARROW_W      64
`define SFP_FIFO_DEPTH    4
`define SFP_FAB_DIV       3
`define SFP_PRI_W         3
`define SFP_TGT_W         4

// ****************************************
// slave endpoints
// ****************************************
`define SFP_SLV_TURBO     4'h0
`define SFP_SLV_VITERBI   4'h1
`define SFP_SLV_SERPORTS  4'h2
`define SFP_SLV_ATM       4'h3
`define SFP_SLV_CFG       4'h4
`define SFP_SLV_SBRIDGE   4'h5
`define SFP_SLV_PCI       4'h6
`define SFP_SLV_DDR2      4'h7
`define SFP_SLV_EMIF      4'h8
`define SFP_SLV_CORE      4'h9
`define SFP_NARROW_MASK   10'h183

// ****************************************
// requesters
// ****************************************
`define SFP_REQ_TC0       4'h0
`define SFP_REQ_TC1       4'h1
`define SFP_REQ_TC2       4'h2
`define SFP_REQ_TC3       4'h3
`define SFP_REQ_ETH       4'h4
`define SFP_REQ_HOST      4'h5
`define SFP_REQ_PCI       4'h6
`define SFP_REQ_LDESC     4'h7
`define SFP_REQ_LDATA     4'h8
`define SFP_REQ_CORE      4'h9
`define SFP_REQ_SBRIDGE   4'ha
`define SFP_REQ_CORE_CFG  4'hb

// ****************************************
// reach masks, bit n = slave n
// ****************************************
`define SFP_REACH_TC0     10'h383
`define SFP_REACH_TC1     10'h3fc
`define SFP_REACH_TC23    10'h3e0
`define SFP_REACH_ETH     10'h380
`define SFP_REACH_HOST    10'h3b0
`define SFP_REACH_LINK    10'h390
`define SFP_REACH_CORE    10'h1ff
`define SFP_REACH_CFGONLY 10'h010

// ****************************************
// core-only config targets
// ****************************************
`define SFP_CFG_PROT_MASK 16'h0007

// ****************************************
// reset priorities
// ****************************************
`define SFP_RST_PRI_TC    3'h0
`define SFP_RST_PRI_LINK  3'h0
`define SFP_RST_PRI_ETH   3'h1
`define SFP_RST_PRI_HOST  3'h2
`define SFP_RST_PRI_CORE  3'h7
`define SFP_RST_PRI_SBR   3'h3

`endif

// File: sfp_pkg.sv
package sfp_pkg;
   typedef logic [3:0]  sfp_idx_t;
   typedef logic [2:0]  sfp_pri_t;
   typedef logic [3:0]  sfp_tgt_t;
   typedef logic [127:0] sfp_data_t;
endpackage : sfp_pkg

// File: sfp_fabric.sv
// Functional notes
// - data fabric moves 128-bit words
// - fabric runs at one third ref_clk
// - config endpoint carries 32-bit words
// - transfer controllers reach only listed slaves
// - other masters reach only listed slaves
// - link has separate descriptor and data ports
// - each transfer controller has own port
// - tc1, host, pci, link, bridge and core reach config fabric endpoint
// - device config and pll: core config port only
// - per-master priority, lower value wins
// - contention resolved by programmed priority
// - config endpoint arbitrated as one endpoint
// - core config port competes by priority
// - host field sets host and pci
// - separate ethernet and bridge priority fields
// - descriptor field governs link descriptor only
// - core, link data, controllers: local priority
// - controllers and link reset to 0
// - ethernet 1, host/pci 2, core 7
// - 64-bit slaves get two beats per word
// - turbo and viterbi take 64-bit beats
// - memory registers reached by data port
`timescale 1ns/1ps
`include "sfp_map.svh"

// ****************************************
// fifo
// ****************************************
module sfp_fifo #(
   parameter int W = 136,
   parameter int D = 4
) (
   input  wire logic         ref_clk,
   input  wire logic         resetn,
   input  wire logic         in_valid,
   output      logic         in_ready,
   input  wire logic [W-1:0] in_data,
   output      logic         out_valid,
   input  wire logic         out_ready,
   output      logic [W-1:0] out_data
);
   localparam int AW = (D > 1) ? $clog2(D) : 1;
   logic [W-1:0] mem_q [D];
   logic [AW-1:0] wp_q;
   logic [AW-1:0] rp_q;
   logic [AW:0]   cnt_q;
   wire           push;
   wire           pop;

   assign in_ready  = (cnt_q < (AW+1)'(D));
   assign out_valid = (cnt_q != '0);
   assign out_data  = mem_q[rp_q];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // pointers wrap naturally, depth must be a power of two
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         wp_q  <= '0;
         rp_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wp_q <= wp_q + AW'(1);
         end
         if (pop) begin
            rp_q <= rp_q + AW'(1);
         end
         if (push && !pop) begin
            cnt_q <= cnt_q + (AW+1)'(1);
         end else if (pop && !push) begin
            cnt_q <= cnt_q - (AW+1)'(1);
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem_q[wp_q] <= in_data;
      end
   end
endmodule : sfp_fifo

// ****************************************
// switch fabric
// ****************************************
module sfp_fabric (
   input  wire logic                    ref_clk,
   input  wire logic                    resetn,
   input  wire logic [11:0]             m_valid,
   input  wire logic [11:0][3:0]        m_dest,
   input  wire logic [11:0][3:0]        m_cfg_tgt,
   input  wire logic [11:0][127:0]      m_data,
   output      logic [11:0]             m_ready,
   output      logic [11:0]             m_err,
   output      logic [9:0]              s_valid,
   input  wire logic [9:0]              s_ready,
   output      logic [9:0][127:0]       s_data,
   output      logic [9:0][3:0]         s_src,
   output      logic [9:0][3:0]         s_tgt,
   input  wire logic                    alloc_we,
   input  wire logic [2:0]              host_priority_field,
   input  wire logic [2:0]              ethernet_priority_field,
   input  wire logic [2:0]              sbridge_priority_field,
   input  wire logic [2:0]              descriptor_priority_field,
   input  wire logic [3:0]              queue_pri_we,
   input  wire logic [3:0][2:0]         queue_priority_field,
   input  wire logic                    link_pri_we,
   input  wire logic [2:0]              link_data_priority_field,
   input  wire logic                    core_pri_we,
   input  wire logic [2:0]              core_master_priority_field,
   output      logic                    fab_en
);
   localparam int NR = `SFP_NUM_REQ;
   localparam int NS = `SFP_NUM_SLV;
   localparam int FW = `SFP_DATA_W + 8;

   // ****************************************
   // decode helpers
   // ****************************************
   function automatic logic [9:0] reach(input logic [3:0] r);
      logic [9:0] m;
      m = 10'h000;
      case (r)
         `SFP_REQ_TC0:      m = `SFP_REACH_TC0;
         `SFP_REQ_TC1:      m = `SFP_REACH_TC1;
         `SFP_REQ_TC2:      m = `SFP_REACH_TC23;
         `SFP_REQ_TC3:      m = `SFP_REACH_TC23;
         `SFP_REQ_ETH:      m = `SFP_REACH_ETH;
         `SFP_REQ_HOST:     m = `SFP_REACH_HOST;
         `SFP_REQ_PCI:      m = `SFP_REACH_HOST;
         `SFP_REQ_LDESC:    m = `SFP_REACH_LINK;
         `SFP_REQ_LDATA:    m = `SFP_REACH_LINK;
         `SFP_REQ_CORE:     m = `SFP_REACH_CORE;
         `SFP_REQ_SBRIDGE:  m = `SFP_REACH_LINK;
         `SFP_REQ_CORE_CFG: m = `SFP_REACH_CFGONLY;
         default:           m = 10'h000;
      endcase
      return m;
   endfunction : reach

   // lowest value wins, ties rotate from the pointer
   function automatic logic [4:0] pick(input logic [11:0] req,
                                       input logic [11:0][2:0] pri,
                                       input logic [3:0] ptr);
      logic [2:0] best;
      logic       found;
      logic [3:0] idx;
      int         k;
      best  = 3'h7;
      found = 1'b0;
      idx   = 4'h0;
      for (int i = 0; i < NR; i++) begin
         if (req[i] && (pri[i] < best)) begin
            best = pri[i];
         end
      end
      for (int j = 0; j < NR; j++) begin
         k = (int'(ptr) + j) % NR;
         if (!found && req[k] && (pri[k] == best)) begin
            found = 1'b1;
            idx   = 4'(k);
         end
      end
      return {found, idx};
   endfunction : pick

   // ****************************************
   // fabric clock enable
   // ****************************************
   logic [1:0] div_q;
   wire        en_d;

   assign en_d = (div_q == 2'(`SFP_FAB_DIV - 1));

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         div_q  <= 2'h0;
         fab_en <= 1'b0;
      end else begin
         div_q  <= en_d ? 2'h0 : div_q + 2'h1;
         fab_en <= en_d;
      end
   end

   // ****************************************
   // priority registers
   // ****************************************
   logic [2:0]      host_pri_q;
   logic [2:0]      eth_pri_q;
   logic [2:0]      sbr_pri_q;
   logic [2:0]      desc_pri_q;
   logic [3:0][2:0] queue_pri_q;
   logic [2:0]      link_pri_q;
   logic [2:0]      core_pri_q;
   logic [11:0][2:0] rpri;

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         host_pri_q <= `SFP_RST_PRI_HOST;
         eth_pri_q  <= `SFP_RST_PRI_ETH;
         sbr_pri_q  <= `SFP_RST_PRI_SBR;
         desc_pri_q <= `SFP_RST_PRI_LINK;
      end else if (alloc_we) begin
         host_pri_q <= host_priority_field;
         eth_pri_q  <= ethernet_priority_field;
         sbr_pri_q  <= sbridge_priority_field;
         desc_pri_q <= descriptor_priority_field;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         link_pri_q <= `SFP_RST_PRI_LINK;
         core_pri_q <= `SFP_RST_PRI_CORE;
      end else begin
         if (link_pri_we) begin
            link_pri_q <= link_data_priority_field;
         end
         if (core_pri_we) begin
            core_pri_q <= core_master_priority_field;
         end
      end
   end

   genvar q;
   generate
      for (q = 0; q < 4; q++) begin : g_qpri
         always_ff @(posedge ref_clk) begin
            if (!resetn) begin
               queue_pri_q[q] <= `SFP_RST_PRI_TC;
            end else if (queue_pri_we[q]) begin
               queue_pri_q[q] <= queue_priority_field[q];
            end
         end
         assign rpri[q] = queue_pri_q[q];
      end
   endgenerate

   assign rpri[`SFP_REQ_ETH]      = eth_pri_q;
   assign rpri[`SFP_REQ_HOST]     = host_pri_q;
   assign rpri[`SFP_REQ_PCI]      = host_pri_q;
   assign rpri[`SFP_REQ_LDESC]    = desc_pri_q;
   assign rpri[`SFP_REQ_LDATA]    = link_pri_q;
   assign rpri[`SFP_REQ_CORE]     = core_pri_q;
   assign rpri[`SFP_REQ_SBRIDGE]  = sbr_pri_q;
   assign rpri[`SFP_REQ_CORE_CFG] = core_pri_q;

   // ****************************************
   // request legality
   // ****************************************
   logic [11:0] legal;
   logic [11:0] err_d;
   logic [9:0][11:0] gnt;
   logic [11:0] rdy_d;

   genvar r;
   generate
      for (r = 0; r < NR; r++) begin : g_req
         wire [9:0] rm   = reach(4'(r));
         wire       inr  = (m_dest[r] < 4'(NS));
         wire       cfg  = (m_dest[r] == `SFP_SLV_CFG);
         wire [15:0] pm  = `SFP_CFG_PROT_MASK >> m_cfg_tgt[r];
         wire       prot = pm[0];
         wire       blk  = cfg && prot && (4'(r) != `SFP_REQ_CORE_CFG);
         assign legal[r] = inr && rm[m_dest[r]] && !blk;
         assign err_d[r] = fab_en && m_valid[r] && !legal[r];
      end
   endgenerate

   always_comb begin
      rdy_d = 12'h000;
      for (int s = 0; s < NS; s++) begin
         rdy_d = rdy_d | gnt[s];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         m_ready <= 12'h000;
         m_err   <= 12'h000;
      end else begin
         m_ready <= rdy_d;
         m_err   <= err_d;
      end
   end

   // ****************************************
   // per-slave arbitration and output
   // ****************************************
   logic [3:0]   ptr_q [NS];
   logic         ov_q  [NS];
   logic         beat_q[NS];
   logic [127:0] sd_q  [NS];
   logic [3:0]   src_q [NS];
   logic [3:0]   tgt_q [NS];

   genvar s;
   generate
      for (s = 0; s < NS; s++) begin : g_slv
         localparam logic [9:0] NMS = `SFP_NARROW_MASK >> s;
         localparam logic NAR = NMS[0];
         localparam logic ISC = (s == int'(`SFP_SLV_CFG));
         wire [11:0]   req;
         wire [4:0]    pk;
         wire          f_in_rdy;
         wire          push;
         wire [FW-1:0] f_in;
         wire          hd_v;
         wire [FW-1:0] hd;
         wire          take;
         wire          first;
         wire          pop;
         wire [127:0]  word;

         // all config targets share this one endpoint
         for (genvar k = 0; k < NR; k++) begin : g_rq
            assign req[k] = m_valid[k] && legal[k] && (m_dest[k] == 4'(s));
         end

         assign pk   = pick(req, rpri, ptr_q[s]);
         assign push = fab_en && pk[4] && f_in_rdy;
         assign f_in = {m_cfg_tgt[pk[3:0]], pk[3:0], m_data[pk[3:0]]};
         assign gnt[s] = push ? (12'h001 << pk[3:0]) : 12'h000;

         sfp_fifo #(
            .W (FW),
            .D (`SFP_FIFO_DEPTH)
         ) u_fifo (
            .ref_clk   (ref_clk),
            .resetn    (resetn),
            .in_valid  (fab_en && pk[4]),
            .in_ready  (f_in_rdy),
            .in_data   (f_in),
            .out_valid (hd_v),
            .out_ready (pop),
            .out_data  (hd)
         );

         assign take  = !ov_q[s] || s_ready[s];
         assign first = NAR && !beat_q[s];
         assign pop   = take && hd_v && !first;
         assign word  = NAR ? {64'h0, (beat_q[s] ? hd[127:64] : hd[63:0])}
                      : ISC ? {96'h0, hd[31:0]}
                      : hd[127:0];

         always_ff @(posedge ref_clk) begin
            if (!resetn) begin
               ptr_q[s] <= 4'h0;
            end else if (push) begin
               ptr_q[s] <= (pk[3:0] == 4'(NR - 1)) ? 4'h0 : pk[3:0] + 4'h1;
            end
         end

         always_ff @(posedge ref_clk) begin
            if (!resetn) begin
               ov_q[s]   <= 1'b0;
               beat_q[s] <= 1'b0;
               sd_q[s]   <= 128'h0;
               src_q[s]  <= 4'h0;
               tgt_q[s]  <= 4'h0;
            end else if (take) begin
               ov_q[s] <= hd_v;
               if (hd_v) begin
                  beat_q[s] <= first;
                  sd_q[s]   <= word;
                  src_q[s]  <= hd[131:128];
                  tgt_q[s]  <= hd[135:132];
               end
            end
         end

         assign s_valid[s] = ov_q[s];
         assign s_data[s]  = sd_q[s];
         assign s_src[s]   = src_q[s];
         assign s_tgt[s]   = tgt_q[s];
      end
   endgenerate
endmodule : sfp_fabric

// File: sfp_fabric_assertions.sv
`timescale 1ns/1ps
// ********
// port checker
// ********
module sfp_fabric_chk (
   input wire logic              ref_clk,
   input wire logic              resetn,
   input wire logic [11:0]       m_valid,
   input wire logic [11:0][3:0]  m_dest,
   input wire logic [11:0][3:0]  m_cfg_tgt,
   input wire logic [11:0]       m_ready,
   input wire logic [11:0]       m_err,
   input wire logic [9:0]        s_valid,
   input wire logic [9:0]        s_ready,
   input wire logic [9:0][127:0] s_data,
   input wire logic              fab_en
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!resetn);

   a_fab_third: assert property (fab_en |=> (!fab_en) [*2] ##1 fab_en)
      else $error("enable period wrong");
   a_take_on_en: assert property (|(m_ready | m_err) |-> $past(fab_en))
      else $error("answer without enable");
   a_answer_excl: assert property ((m_ready & m_err) == 12'h000)
      else $error("ready and refusal together");
   a_tc0_reach: assert property (fab_en && m_valid[0] && m_dest[0] inside {[4'h2:4'h6]}
      |=> m_err[0])
      else $error("controller 0 not refused");
   a_eth_reach: assert property (fab_en && m_valid[4] && m_dest[4] < 4'h7 |=> m_err[4])
      else $error("ethernet not refused");
   a_prot_cfg: assert property (fab_en && m_valid[5] && m_dest[5] == 4'h4
      && m_cfg_tgt[5] < 4'h3 |=> m_err[5])
      else $error("protected target reached");
   a_core_cfg_ok: assert property (fab_en && m_valid[11] && m_dest[11] == 4'h4
      |=> !m_err[11])
      else $error("core config port refused");
   a_cfg_width: assert property (s_valid[4] |-> s_data[4][127:32] == 96'h0)
      else $error("config word too wide");
   a_ddr_beat: assert property (s_valid[7] |-> s_data[7][127:64] == 64'h0)
      else $error("memory beat too wide");
   a_coproc_beat: assert property (s_valid[0] |-> s_data[0][127:64] == 64'h0)
      else $error("coprocessor beat too wide");
   a_hold_word: assert property (s_valid[9] && !s_ready[9]
      |=> s_valid[9] && $stable(s_data[9]))
      else $error("word dropped while stalled");

   c_refused: cover property (m_err[0]);
   c_cfg_port: cover property (m_ready[11]);
   c_stall: cover property ((s_valid[9] && !s_ready[9]) [*3]);
endmodule : sfp_fabric_chk

bind sfp_fabric sfp_fabric_chk sfp_fabric_chk_inst (
   .ref_clk, .resetn, .m_valid, .m_dest, .m_cfg_tgt, .m_ready,
   .m_err, .s_valid, .s_ready, .s_data, .fab_en
);

// File: sfp_slave_model.sv
`timescale 1ns/1ps
// ********
// slave side model
// ********
module sfp_slave_model (
   input  wire logic       ref_clk,
   input  wire logic       resetn,
   input  wire logic [9:0] hold,
   input  wire logic       slow,
   output      logic [9:0] s_ready
);
   logic ph_q;
   logic ph_d;
   assign ph_d = resetn & ~ph_q;
   always_ff @(posedge ref_clk) begin
      ph_q <= ph_d;
   end
   // slow mode accepts every other cycle
   assign s_ready = ~hold & {10{~slow | ph_q}};
endmodule : sfp_slave_model

// File: sfp_fabric_test.sv
`timescale 1ns/1ps
// ********
// fabric bench
// ********
module sfp_fabric_test;
   logic               ref_clk = 1'b0;
   logic               resetn = 1'b0;
   logic [11:0]        m_valid = 12'h000;
   logic [11:0][3:0]   m_dest = '0;
   logic [11:0][3:0]   m_cfg_tgt = '0;
   logic [11:0][127:0] m_data = '0;
   logic [11:0]        m_ready;
   logic [11:0]        m_err;
   logic [9:0]         s_valid;
   logic [9:0]         s_ready;
   logic [9:0][127:0]  s_data;
   logic [9:0][3:0]    s_src;
   logic [9:0][3:0]    s_tgt;
   logic               alloc_we = 1'b0;
   logic [3:0][2:0]    alloc_f = '0;
   logic [3:0]         q_we = 4'h0;
   logic [3:0][2:0]    q_pri = '0;
   logic               loc_we = 1'b0;
   logic [2:0]         loc_pri = 3'h0;
   logic [9:0]         hold = 10'h000;
   logic               slow = 1'b0;
   logic               e;
   int                 miscompares = 0;
   int                 checked = 0;
   int                 cycles = 0;
   // requester, slave, config target, refused
   logic [15:0]        tab [23] = '{16'h0201, 16'h0000, 16'h0100, 16'h1430, 16'h2301,
      16'h3600, 16'h4501, 16'h4700, 16'h5601, 16'h6500, 16'h7501, 16'h8800, 16'h9901,
      16'h9100, 16'ha900, 16'h0c01, 16'h5401, 16'h6421, 16'h9411, 16'hb400, 16'hb420,
      16'h5430, 16'hb701};

   sfp_fabric sfp_fabric_inst (
      .ref_clk, .resetn, .m_valid, .m_dest, .m_cfg_tgt, .m_data, .m_ready, .m_err,
      .s_valid, .s_ready, .s_data, .s_src, .s_tgt, .alloc_we,
      .host_priority_field(alloc_f[0]), .ethernet_priority_field(alloc_f[1]),
      .sbridge_priority_field(alloc_f[2]), .descriptor_priority_field(alloc_f[3]),
      .queue_pri_we(q_we), .queue_priority_field(q_pri),
      .link_pri_we(loc_we), .link_data_priority_field(loc_pri),
      .core_pri_we(loc_we), .core_master_priority_field(loc_pri), .fab_en());

   sfp_slave_model sfp_slave_model_inst (.ref_clk, .resetn, .hold, .slow, .s_ready);

   always #4 ref_clk = ~ref_clk;

   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         $display("wrong value at %0t: run hung", $time);
         wrap_up();
      end
   end

   task automatic wrap_up;
      $display("checks %0d, mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : wrap_up

   task automatic chk(input logic [127:0] got, input logic [127:0] exp, input string m);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask : chk

   task automatic send(input int r, input int d, input int t, input sfp_pkg::sfp_data_t w,
                       output logic x);
      int n;
      n = 0;
      @(posedge ref_clk);
      m_dest[r] <= 4'(d);
      m_cfg_tgt[r] <= 4'(t);
      m_data[r] <= w;
      m_valid[r] <= 1'b1;
      do begin
         @(negedge ref_clk);
         n++;
      end while (!(m_ready[r] | m_err[r]) && n < 60);
      chk(128'(n < 60), 128'h1, "no answer");
      x = m_err[r];
      @(posedge ref_clk);
      m_valid[r] <= 1'b0;
   endtask : send

   task automatic get(input int s, input int src, input int t, input sfp_pkg::sfp_data_t w);
      int n;
      n = 0;
      do begin
         @(negedge ref_clk);
         n++;
      end while (!(s_valid[s] & s_ready[s]) && n < 60);
      chk(128'(s_src[s]), 128'(src), "beat source");
      chk(s_data[s], w, "beat data");
      if (s == 4) chk(128'(s_tgt[4]), 128'(t), "config target");
      @(posedge ref_clk);
   endtask : get

   task automatic beats(input int d, input int r, input int t, input sfp_pkg::sfp_data_t w);
      if (d inside {0, 1, 7, 8}) begin
         get(d, r, t, {64'h0, w[63:0]});
         get(d, r, t, {64'h0, w[127:64]});
      end else if (d == 4) begin
         get(d, r, t, {96'h0, w[31:0]});
      end else begin
         get(d, r, t, w);
      end
   endtask : beats

   task automatic race(input int a, input int b, input int d);
      logic ea;
      logic eb;
      // stall the slave so both words wait in order
      hold[d] <= 1'b1;
      fork
         send(a, d, 3, {4{32'(a)}}, ea);
         send(b, d, 3, {4{32'(b)}}, eb);
      join
      hold[d] <= 1'b0;
      beats(d, a, 3, {4{32'(a)}});
      beats(d, b, 3, {4{32'(b)}});
   endtask : race

   task automatic set_pri(input logic [3:0][2:0] a, input logic [2:0] q, input logic [2:0] l);
      @(posedge ref_clk);
      alloc_f <= a;
      alloc_we <= 1'b1;
      q_pri <= {4{q}};
      q_we <= 4'hf;
      loc_pri <= l;
      loc_we <= 1'b1;
      @(posedge ref_clk);
      alloc_we <= 1'b0;
      q_we <= 4'h0;
      loc_we <= 1'b0;
   endtask : set_pri

   initial begin
      sfp_pkg::sfp_data_t w;
      repeat (8) @(posedge ref_clk);
      resetn <= 1'b1;
      // ********
      // reach and protection
      // ********
      foreach (tab[i]) begin
         w = {64'h0123456789abcdef, 64'hfedcba9876543210} ^ 128'(i);
         send(int'(tab[i][15:12]), int'(tab[i][11:8]), int'(tab[i][7:4]), w, e);
         chk(128'(e), 128'(tab[i][0]), "refusal");
         if (e === 1'b0) beats(int'(tab[i][11:8]), int'(tab[i][15:12]), int'(tab[i][7:4]), w);
      end
      $display("test reach done");
      // ********
      // priorities
      // ********
      race(4, 5, 7);
      race(2, 4, 7);
      race(7, 6, 8);
      race(4, 9, 7);
      set_pri({3'h6, 3'h2, 3'h4, 3'h0}, 3'h5, 3'h1);
      race(5, 4, 7);
      race(6, 2, 7);
      race(10, 7, 8);
      race(9, 10, 8);
      race(8, 7, 7);
      race(5, 9, 4);
      race(6, 11, 4);
      $display("test priority done");
      // ********
      // buffer fill and drain
      // ********
      @(posedge ref_clk);
      hold <= 10'h200;
      for (int i = 0; i < 5; i++) send(1, 9, 3, {4{32'(i)}}, e);
      fork
         send(1, 9, 3, {4{32'h5}}, e);
         begin
            repeat (15) begin
               @(negedge ref_clk);
               chk(128'(m_ready[1]), 128'h0, "full buffer took word");
            end
            @(posedge ref_clk);
            hold <= 10'h000;
            slow <= 1'b1;
            for (int i = 0; i < 6; i++) get(9, 1, 3, {4{32'(i)}});
         end
      join
      repeat (4) @(negedge ref_clk);
      chk(128'(s_valid[9]), 128'h0, "buffer not empty");
      $display("test buffer done");
      wrap_up();
   end
endmodule : sfp_fabric_test
